// ==== sgan_mdio_station.sv ====
// Station management model that runs frames on the serial management pins
`timescale 1ns/1ps
`default_nettype none
module sgan_mdio_station (
  input wire logic clk_sys,
  input wire logic mdio_wire,
  output logic mdc,
  output logic m_out,
  output logic m_oe,
  output logic rd_done,
  output logic [15:0] rd_data
);
  logic smp;
  initial begin
    mdc = 1'b0;
    m_out = 1'b1;
    m_oe = 1'b0;
    rd_done = 1'b0;
    rd_data = 16'h0000;
    smp = 1'b0;
  end
  // ----------------------------------------
  // One bit: drive while the clock is low, sample just before it rises
  // ----------------------------------------
  task automatic bit_cycle(input logic drv, input logic val);
    @(negedge clk_sys);
    mdc = 1'b0;
    m_oe = drv;
    m_out = drv ? val : ~m_out;
    repeat (3) @(negedge clk_sys);
    smp = mdio_wire;
    mdc = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask
  // ----------------------------------------
  // Whole frame with short preamble; released lines fall to the pull-up
  // ----------------------------------------
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] hdr;
    logic [15:0] rd;
    logic is_wr;
    hdr = {2'h3, 1'b0, 1'b1, op, phy, ra};
    is_wr = (op == 2'h1);
    rd = 16'h0000;
    for (int i = 15; i >= 0; i--) bit_cycle(1'b1, hdr[i]);
    bit_cycle(is_wr, 1'b1);
    bit_cycle(is_wr, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(is_wr, wd[i]);
      rd = {rd[14:0], smp};
    end
    @(negedge clk_sys);
    mdc = 1'b0;
    m_oe = 1'b0;
    if (!is_wr) begin
      rd_data = rd;
      rd_done = 1'b1;
      @(negedge clk_sys);
      rd_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== sgan_mgmt_regs.sv ====
// Negotiation management registers behind a serial management slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Partner link bit reads medium link, resets 1
// - Partner acknowledge bit read-only, set on page
// - Partner duplex and speed read-only, reset zero
// - Partner bit0 reads 1; bits13,9:1 read 0
// - Page received flag clears on read
// - Expansion bit2 reads 1, bit1 is page flag, others zero
// - Next page transmit resets to null message
// - Toggle bits read-only, alternate per page
// - Code field meaning follows message page bit
// - Next page receive register fully read-only
// - Acknowledge-2 writable transmit, read-only receive
// - Extended status reads only bit15 set
// - Completion sets status if enabled; writing 0 to status or to enable clears
// - Interrupt pin follows status bit
// - Enable bit read/write, resets 1; rest zero
module sgan_mgmt_regs (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_b,
  input wire logic [4:0] phy_addr,
  input wire logic lp_page_valid,
  input wire logic lp_link_up,
  input wire logic lp_ack,
  input wire logic lp_full_duplex,
  input wire logic [1:0] lp_speed,
  input wire logic page_rx,
  input wire logic np_rx_valid,
  input wire logic [15:0] np_rx_word,
  input wire logic np_tx_sent,
  input wire logic neg_done,
  output logic [15:0] np_tx_word,
  output logic negotiation_done_irq_out
);
  // ----------------------------------------
  // Frame engine state
  // ----------------------------------------
  sgan_pkg::sgan_state_t state;
  sgan_pkg::sgan_state_t next_state;
  logic mdc_q;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [12:0] hdr;
  logic [15:0] sh;
  logic armed;
  logic own;
  logic is_read;
  logic [4:0] reg_addr;
  logic [15:0] rdata;

  wire rise = mdc & ~mdc_q;
  wire st_idle = (state == sgan_pkg::SGAN_IDLE);
  wire st_hdr = (state == sgan_pkg::SGAN_HDR);
  wire st_ta = (state == sgan_pkg::SGAN_TA);
  wire st_data = (state == sgan_pkg::SGAN_DATA);
  wire [12:0] hdr_next = {hdr[11:0], mdio_in};
  wire hdr_start_ok = hdr_next[12];
  wire [1:0] hdr_op = hdr_next[11:10];
  wire [4:0] hdr_pa = hdr_next[9:5];
  wire [4:0] hdr_ra = hdr_next[4:0];
  wire op_rd = (hdr_op == sgan_pkg::OP_READ);
  wire op_wr = (hdr_op == sgan_pkg::OP_WRITE);
  wire hdr_match = hdr_start_ok & (hdr_pa == phy_addr) & (op_rd | op_wr);
  wire start = st_idle & rise & armed & ~mdio_in;
  wire hdr_done = st_hdr & rise & (cnt == sgan_pkg::HDR_LAST);
  wire ta_first = st_ta & rise & (cnt == 4'h0);
  wire ta_last = st_ta & rise & (cnt == sgan_pkg::TA_LAST);
  wire data_last = st_data & rise & (cnt == sgan_pkg::DATA_LAST);
  wire shift_en = ta_last | (st_data & rise);
  wire rd_en = ta_first & own & is_read;
  wire wr_en = data_last & own & ~is_read;
  wire [15:0] wr_data = {sh[14:0], mdio_in};
  wire drive_bit = shift_en & ~data_last & own & is_read;

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      sgan_pkg::SGAN_IDLE: begin
        if (start) begin
          next_state = sgan_pkg::SGAN_HDR;
        end
      end
      sgan_pkg::SGAN_HDR: begin
        if (hdr_done) begin
          next_state = sgan_pkg::SGAN_TA;
        end
      end
      sgan_pkg::SGAN_TA: begin
        if (ta_last) begin
          next_state = sgan_pkg::SGAN_DATA;
        end
      end
      sgan_pkg::SGAN_DATA: begin
        if (data_last) begin
          next_state = sgan_pkg::SGAN_IDLE;
        end
      end
    endcase
  end

  assign next_cnt = (next_state != state) ? 4'h0 : (rise ? cnt + 4'h1 : cnt);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= sgan_pkg::SGAN_IDLE;
      cnt <= 4'h0;
      mdc_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mdc_q <= mdc;
    end
  end

  // A start bit is only taken after a one, so short preambles work
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (!st_idle) begin
      armed <= 1'b0;
    end else if (rise && mdio_in) begin
      armed <= 1'b1;
    end
  end

  // Frames for other addresses are tracked to their end but not answered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hdr <= 13'h0000;
      own <= 1'b0;
      is_read <= 1'b0;
      reg_addr <= 5'h00;
    end else if (start) begin
      hdr <= 13'h0000;
    end else if (st_hdr && rise) begin
      hdr <= hdr_next;
      if (hdr_done) begin
        own <= hdr_match;
        is_read <= op_rd;
        reg_addr <= hdr_ra;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sh <= 16'h0000;
    end else if (rd_en) begin
      sh <= rdata;
    end else if (shift_en) begin
      sh <= wr_data;
    end
  end

  // Turnaround drives zero in its second bit, then data msb first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mdio_out <= 1'b0;
      mdio_oe_b <= 1'b1;
    end else if (rd_en) begin
      mdio_out <= 1'b0;
      mdio_oe_b <= 1'b0;
    end else if (drive_bit) begin
      mdio_out <= sh[15];
    end else if (data_last || st_idle) begin
      mdio_out <= 1'b0;
      mdio_oe_b <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic lp_link;
  logic lp_ack_q;
  logic lp_duplex;
  logic [1:0] lp_speed_q;
  logic page_flag;
  logic np_next;
  logic np_msg;
  logic np_ack2;
  logic np_toggle;
  logic [10:0] np_code;
  logic [15:0] np_rx;
  logic irq_en;
  logic irq_stat;
  logic np_touched;

  wire wr_tx = wr_en & (reg_addr == sgan_pkg::ADDR_NP_TX);
  wire wr_irq = wr_en & (reg_addr == sgan_pkg::ADDR_IRQ_CTRL);
  wire rd_exp = rd_en & (reg_addr == sgan_pkg::ADDR_EXPANSION);
  wire irq_clr = wr_irq & ~wr_data[sgan_pkg::IRQ_STAT_BIT];
  wire next_irq_en = wr_irq ? wr_data[sgan_pkg::IRQ_EN_BIT] : irq_en;
  wire next_irq_stat = next_irq_en & (neg_done | (irq_stat & ~irq_clr));
  wire next_page_flag = page_rx | (page_flag & ~rd_exp);

  // Partner base page fields, captured when the negotiation hands one over
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lp_link <= sgan_pkg::LP_LINK_RST;
      lp_ack_q <= 1'b0;
      lp_duplex <= 1'b0;
      lp_speed_q <= sgan_pkg::SPEED_10M;
    end else if (lp_page_valid) begin
      lp_link <= lp_link_up;
      lp_ack_q <= lp_ack;
      lp_duplex <= lp_full_duplex;
      lp_speed_q <= lp_speed;
    end
  end

  // A page arriving in the clearing read's cycle stays visible
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      page_flag <= 1'b0;
    end else begin
      page_flag <= next_page_flag;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      np_next <= 1'b0;
      np_msg <= sgan_pkg::NP_MSG_RST;
      np_ack2 <= 1'b0;
      np_code <= sgan_pkg::NULL_MSG_CODE;
    end else if (wr_tx) begin
      np_next <= wr_data[sgan_pkg::NP_NEXT_BIT];
      np_msg <= wr_data[sgan_pkg::NP_MSG_BIT];
      np_ack2 <= wr_data[sgan_pkg::NP_ACK2_BIT];
      np_code <= wr_data[sgan_pkg::NP_CODE_HI:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      np_toggle <= 1'b0;
      np_rx <= 16'h0000;
    end else begin
      np_toggle <= np_toggle ^ np_tx_sent;
      if (np_rx_valid) begin
        np_rx <= np_rx_word;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= sgan_pkg::IRQ_EN_RST;
      irq_stat <= 1'b0;
    end else begin
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
    end
  end

  assign np_tx_word = {np_next, 1'b0, np_msg, np_ack2, np_toggle, np_code};
  assign negotiation_done_irq_out = irq_stat;

  sgan_rd_mux u_rd_mux (
    .addr(reg_addr),
    .lp_link(lp_link),
    .lp_ack(lp_ack_q),
    .lp_duplex(lp_duplex),
    .lp_speed(lp_speed_q),
    .page_flag(page_flag),
    .np_tx_word(np_tx_word),
    .np_rx_word(np_rx),
    .irq_stat(irq_stat),
    .irq_en(irq_en),
    .rdata(rdata)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      np_touched <= 1'b0;
    end else if (wr_tx) begin
      np_touched <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  lp_link_a: assert property (lp_page_valid |=> lp_link == $past(lp_link_up))
    else $error("partner link bit not captured");
  lp_ack_a: assert property (lp_page_valid ##1 !lp_page_valid |=> $stable(lp_ack_q))
    else $error("partner acknowledge changed without a page");
  lp_speed_a: assert property (lp_page_valid |=> lp_speed_q == $past(lp_speed))
    else $error("partner speed not captured");
  lp_fixed_a: assert property ((reg_addr == sgan_pkg::ADDR_LP_BASE) |->
      rdata[13] == 1'b0 && rdata[9:1] == 9'h000 && rdata[0])
    else $error("partner fixed bits wrong");
  page_clear_a: assert property (rd_exp && !page_rx |=> !page_flag ##1 (page_flag || !$past(page_rx)))
    else $error("page flag not cleared by read");
  page_set_a: assert property (page_rx |=> page_flag)
    else $error("page flag lost");
  exp_fixed_a: assert property ((reg_addr == sgan_pkg::ADDR_EXPANSION) |->
      rdata[15:3] == 13'h0000 && rdata[2] && !rdata[0])
    else $error("expansion fixed bits wrong");
  np_default_a: assert property (!np_touched |-> np_tx_word[15:12] == 4'h2 &&
      np_tx_word[10:0] == sgan_pkg::NULL_MSG_CODE)
    else $error("next page transmit default wrong");
  toggle_a: assert property (np_tx_sent |=> np_toggle != $past(np_toggle))
    else $error("toggle did not alternate");
  np_rx_a: assert property (np_rx_valid |=> np_rx == $past(np_rx_word))
    else $error("next page receive not captured");
  ack2_a: assert property (wr_tx |=> np_ack2 == $past(wr_data[sgan_pkg::NP_ACK2_BIT]))
    else $error("acknowledge-2 write lost");
  ext_status_a: assert property ((reg_addr == sgan_pkg::ADDR_EXT_STATUS) |->
      rdata == sgan_pkg::EXT_STATUS_VALUE)
    else $error("extended status wrong");
  irq_set_a: assert property (neg_done && next_irq_en |=> irq_stat ##1 (irq_stat || $past(irq_clr) || !irq_en))
    else $error("interrupt status not set");
  irq_keep_a: assert property (irq_stat && !irq_clr && next_irq_en |=> irq_stat)
    else $error("interrupt status cleared without write");
  irq_hold_a: assert property (!irq_en |-> !irq_stat)
    else $error("status set while disabled");
  irq_pin_a: assert property ((reg_addr == sgan_pkg::ADDR_IRQ_CTRL) |->
      rdata[1] == negotiation_done_irq_out && rdata[15:2] == 14'h0000)
    else $error("interrupt pin differs from status");
  irq_en_a: assert property (wr_irq |=> irq_en == $past(wr_data[sgan_pkg::IRQ_EN_BIT]))
    else $error("enable write lost");
  turn_drive_a: assert property (rd_en |=> !mdio_oe_b && !mdio_out ##1 !mdio_oe_b)
    else $error("turnaround not driven low");
  release_a: assert property (data_last |=> mdio_oe_b)
    else $error("bus not released after data");
  drive_own_a: assert property (!mdio_oe_b |-> own && is_read)
    else $error("driving for a foreign frame");

  read_c: cover property (rd_en ##1 !mdio_oe_b [*8]);
  write_c: cover property (wr_irq);
  irq_c: cover property (neg_done && irq_en ##1 negotiation_done_irq_out);
  page_c: cover property (page_rx ##[1:200] rd_exp);
endmodule
`default_nettype wire

// ==== sgan_mgmt_regs_tb_top.sv ====
// Self-checking bench for the negotiation management registers
`timescale 1ns/1ps
`default_nettype none
module sgan_mgmt_regs_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic mdc, m_out, m_oe, rd_done, mdio_out, mdio_oe_b, mdio_in, irq;
  logic lp_page_valid = 1'b0, lp_link_up = 1'b0, lp_ack = 1'b0, lp_full_duplex = 1'b0;
  logic page_rx = 1'b0, np_rx_valid = 1'b0, np_tx_sent = 1'b0, neg_done = 1'b0;
  logic [1:0] lp_speed = 2'h0;
  logic [15:0] np_rx_word = 16'h0000, np_tx_word, rd_data, w;
  logic [4:0] cur_phy;
  logic [15:0] q[$];
  int seed, n_mismatch = 0, checks = 0, cycles = 0;
  localparam logic [4:0] MY_PHY = 5'h0a;
  logic [4:0] ro_a[5] = '{5'h05, 5'h06, 5'h08, 5'h0f, 5'h09};
  logic [15:0] ro_v[5] = '{16'h8001, 16'h0004, 16'h0000, 16'h8000, 16'h0000};

  always #5 clk_sys = ~clk_sys;
  // Tri-state wire with pull-up
  assign mdio_in = !mdio_oe_b ? mdio_out : (m_oe ? m_out : 1'b1);

  sgan_mgmt_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_b(mdio_oe_b), .phy_addr(MY_PHY), .lp_page_valid(lp_page_valid), .lp_link_up(lp_link_up),
    .lp_ack(lp_ack), .lp_full_duplex(lp_full_duplex), .lp_speed(lp_speed), .page_rx(page_rx),
    .np_rx_valid(np_rx_valid), .np_rx_word(np_rx_word), .np_tx_sent(np_tx_sent), .neg_done(neg_done),
    .np_tx_word(np_tx_word), .negotiation_done_irq_out(irq));
  sgan_mdio_station station (.clk_sys(clk_sys), .mdio_wire(mdio_in), .mdc(mdc), .m_out(m_out), .m_oe(m_oe),
    .rd_done(rd_done), .rd_data(rd_data));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    q.push_back(e);
    station.frame(sgan_pkg::OP_READ, cur_phy, a, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    station.frame(sgan_pkg::OP_WRITE, cur_phy, a, d);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  // ----------------------------------------
  // Watcher: every read result against the oldest note
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (rd_done) begin
      if (q.size() == 0) chk("read count", 16'h0000, 16'h0001);
      else chk("read data", q.pop_front(), rd_data);
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 28253;
    cur_phy = MY_PHY;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk("tx word", 16'h2001, np_tx_word);
    chk("irq pin", 16'h0000, {15'h0000, irq});
    rd(sgan_pkg::ADDR_NP_TX, 16'h2001);
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0001);
    for (int i = 0; i < 5; i++) rd(ro_a[i], ro_v[i]);
    for (int i = 0; i < 5; i++) wr(ro_a[i], 16'hffff);
    for (int i = 0; i < 5; i++) rd(ro_a[i], ro_v[i]);
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys);
      lp_link_up = $random(seed);
      lp_ack = $random(seed);
      lp_full_duplex = $random(seed);
      lp_speed = s[1:0];
      pulse(lp_page_valid);
      rd(sgan_pkg::ADDR_LP_BASE, {lp_link_up, lp_ack, 1'b0, lp_full_duplex, lp_speed, 9'h000, 1'b1});
    end
    pulse(page_rx);
    rd(sgan_pkg::ADDR_EXPANSION, 16'h0006);
    rd(sgan_pkg::ADDR_EXPANSION, 16'h0004);
    w = $random(seed);
    np_rx_word = w;
    pulse(np_rx_valid);
    rd(sgan_pkg::ADDR_NP_RX, w);
    wr(sgan_pkg::ADDR_NP_RX, ~w);
    rd(sgan_pkg::ADDR_NP_RX, w);
    wr(sgan_pkg::ADDR_NP_TX, 16'hffff);
    rd(sgan_pkg::ADDR_NP_TX, 16'hb7ff);
    pulse(np_tx_sent);
    chk("tx word", 16'hbfff, np_tx_word);
    rd(sgan_pkg::ADDR_NP_TX, 16'hbfff);
    pulse(np_tx_sent);
    w = $random(seed);
    wr(sgan_pkg::ADDR_NP_TX, w);
    rd(sgan_pkg::ADDR_NP_TX, w & 16'hb7ff);
    chk("tx word", w & 16'hb7ff, np_tx_word);
    // Second reset in mid-run brings back the documented defaults
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk("tx word", 16'h2001, np_tx_word);
    rd(sgan_pkg::ADDR_LP_BASE, 16'h8001);
    pulse(neg_done);
    chk("irq pin", 16'h0001, {15'h0000, irq});
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0003);
    wr(sgan_pkg::ADDR_IRQ_CTRL, 16'h0003);
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0003);
    wr(sgan_pkg::ADDR_IRQ_CTRL, 16'hfffd);
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0001);
    chk("irq pin", 16'h0000, {15'h0000, irq});
    wr(sgan_pkg::ADDR_IRQ_CTRL, 16'h0000);
    pulse(neg_done);
    chk("irq pin", 16'h0000, {15'h0000, irq});
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0000);
    wr(sgan_pkg::ADDR_IRQ_CTRL, 16'h0001);
    rd(sgan_pkg::ADDR_IRQ_CTRL, 16'h0001);
    cur_phy = MY_PHY ^ 5'h01;
    rd(sgan_pkg::ADDR_EXT_STATUS, 16'hffff);
    cur_phy = MY_PHY;
    // Undefined operation code: frame is not answered, line stays pulled up
    q.push_back(16'hffff);
    station.frame(2'h3, cur_phy, sgan_pkg::ADDR_IRQ_CTRL, 16'h0000);
    rd(sgan_pkg::ADDR_EXT_STATUS, 16'h8000);
    repeat (4) @(negedge clk_sys);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== sgan_pkg.sv ====
// Constants and types for the negotiation management register block
package sgan_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_LP_BASE = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TX = 5'h07;
  localparam logic [4:0] ADDR_NP_RX = 5'h08;
  localparam logic [4:0] ADDR_EXT_STATUS = 5'h0f;
  localparam logic [4:0] ADDR_IRQ_CTRL = 5'h10;
  // ----------------------------------------
  // Field positions and fixed values
  // ----------------------------------------
  localparam int LP_LINK_BIT = 15;
  localparam int LP_ACK_BIT = 14;
  localparam int LP_DUPLEX_BIT = 12;
  localparam int LP_SPEED_HI = 11;
  localparam int LP_SPEED_LO = 10;
  localparam logic [15:0] LP_FIXED = 16'h0001;
  localparam logic [15:0] EXP_FIXED = 16'h0004;
  localparam int EXP_PAGE_BIT = 1;
  localparam int NP_NEXT_BIT = 15;
  localparam int NP_MSG_BIT = 13;
  localparam int NP_ACK2_BIT = 12;
  localparam int NP_CODE_HI = 10;
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
  localparam int IRQ_STAT_BIT = 1;
  localparam int IRQ_EN_BIT = 0;
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_10M = 2'h0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic LP_LINK_RST = 1'h1;
  localparam logic NP_MSG_RST = 1'h1;
  localparam logic [10:0] NULL_MSG_CODE = 11'h001;
  localparam logic IRQ_EN_RST = 1'h1;
  // ----------------------------------------
  // Management frame
  // ----------------------------------------
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [3:0] HDR_LAST = 4'hc;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hf;
  typedef enum logic [3:0] {
    SGAN_IDLE = 4'h1,
    SGAN_HDR = 4'h2,
    SGAN_TA = 4'h4,
    SGAN_DATA = 4'h8
  } sgan_state_t;
endpackage

// ==== sgan_rd_mux.sv ====
// Read data selection for the negotiation management registers
`timescale 1ns/1ps
`default_nettype none
module sgan_rd_mux (
  input wire logic [4:0] addr,
  input wire logic lp_link,
  input wire logic lp_ack,
  input wire logic lp_duplex,
  input wire logic [1:0] lp_speed,
  input wire logic page_flag,
  input wire logic [15:0] np_tx_word,
  input wire logic [15:0] np_rx_word,
  input wire logic irq_stat,
  input wire logic irq_en,
  output logic [15:0] rdata
);
  wire [15:0] lp_word;
  wire [15:0] exp_word;
  wire [15:0] irq_word;
  wire sel_lp = (addr == sgan_pkg::ADDR_LP_BASE);
  wire sel_exp = (addr == sgan_pkg::ADDR_EXPANSION);
  wire sel_tx = (addr == sgan_pkg::ADDR_NP_TX);
  wire sel_rx = (addr == sgan_pkg::ADDR_NP_RX);
  wire sel_ext = (addr == sgan_pkg::ADDR_EXT_STATUS);
  wire sel_irq = (addr == sgan_pkg::ADDR_IRQ_CTRL);

  assign lp_word = {lp_link, lp_ack, 1'b0, lp_duplex, lp_speed, 10'h000} | sgan_pkg::LP_FIXED;
  assign exp_word = {14'h0000, page_flag, 1'b0} | sgan_pkg::EXP_FIXED;
  assign irq_word = {14'h0000, irq_stat, irq_en};

  // Unlisted addresses read as zero
  assign rdata = ({16{sel_lp}} & lp_word)
               | ({16{sel_exp}} & exp_word)
               | ({16{sel_tx}} & np_tx_word)
               | ({16{sel_rx}} & np_rx_word)
               | ({16{sel_ext}} & sgan_pkg::EXT_STATUS_VALUE)
               | ({16{sel_irq}} & irq_word);
endmodule
`default_nettype wire
